// ===== verilog/spim_pkg.sv
// Shared constants and types of the serial master control block.
package spim_pkg;
    // Data path geometry.
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int RING_AW = 3;
    localparam logic [RING_AW:0] RING_DEPTH = 4'h8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Register offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_TXDATA = 8'h0c;
    localparam logic [7:0] ADDR_RXDATA = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_COUNT = 8'h18;
    // Command bits of the control register; each is a one-shot action.
    localparam int CTRL_INIT = 0;
    localparam int CTRL_ACTIVATE = 1;
    localparam int CTRL_QUEUE_FLUSH = 2;
    localparam int CTRL_RX_FLUSH = 3;
    localparam int CTRL_TX_FLUSH = 4;
    localparam int CTRL_DRIVE_ON = 5;
    localparam int CTRL_DRIVE_OFF = 6;
    localparam int CTRL_LP_ENTRY = 7;
    localparam int CTRL_LP_EXIT = 8;
    // Configuration fields and reset values.
    localparam int CFG_INT_CLK = 0;
    localparam int CFG_BIDIR = 1;
    localparam int CFG_PERIOD_LSB = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0401;
    localparam logic [15:0] MASK_INIT = 16'h0001;
    // Status bit positions; transmit byte low, receive byte high.
    localparam int ST_DONE = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_TX_NOT_FULL = 2;
    localparam int ST_BYTE_DONE = 3;
    localparam int ST_IDLE = 4;
    localparam int ST_TX_INT = 7;
    localparam int ST_RX_FULL = 12;
    localparam int ST_RX_NOT_EMPTY = 13;
    localparam int ST_RX_OVERRUN = 14;
    localparam int ST_RX_INT = 15;
    localparam int COUNT_RX_LSB = 8;
    // Shift engine states.
    typedef enum logic [1:0] {
        SPIM_IDLE = 2'b01,
        SPIM_SHIFT = 2'b10
    } spim_state_type;
endpackage : spim_pkg

// ===== verilog/spim_stream_if.sv
// Valid and ready word stream between the block's own modules.
`timescale 1ns/1ps
interface spim_stream_if #(parameter int W = 8) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : spim_stream_if

// ===== verilog/spim_fifo.sv
// Small hardware queue with flush that beats any push or pop.
`timescale 1ns/1ps
module spim_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    spim_stream_if.snk in_s,
    spim_stream_if.src out_s
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = D[AW:0];

    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic [AW:0] next_cnt;
    wire push = in_s.valid && in_s.ready;
    wire pop = out_s.valid && out_s.ready;

    // Handshake flags come straight from the occupancy count.
    assign in_s.ready = (cnt != FULL);
    assign out_s.valid = (cnt != '0);
    assign out_s.data = mem[rptr];
    assign next_cnt = flush_i ? '0 : cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Pointers and count; a flush empties the queue outright.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
        end
        else
        begin
            wptr <= flush_i ? '0 : wptr + AW'(push);
            rptr <= flush_i ? '0 : rptr + AW'(pop);
            cnt <= next_cnt;
        end
    end

    // Storage needs no reset; the count says what is valid.
    always_ff @(posedge clk_i)
    begin
        if (push && !flush_i)
            mem[wptr] <= in_s.data;
    end
endmodule : spim_fifo

// ===== verilog/spim_ring_mem.sv
// Circular buffer storage with a registered, write-bypassed read port.
`timescale 1ns/1ps
module spim_ring_mem #(
    parameter int W = 8,
    parameter int AW = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [W-1:0] rd_data_o
);
    logic [W-1:0] mem [2**AW];

    // Array write.
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
            mem[wr_addr_i] <= wr_data_i;
    end

    // Read register; a same-cycle write to the read address is forwarded.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_data_o <= '0;
        else if (wr_en_i && (wr_addr_i == rd_addr_i))
            rd_data_o <= wr_data_i;
        else
            rd_data_o <= mem[rd_addr_i];
    end
endmodule : spim_ring_mem

// ===== verilog/spim_control.sv
// Serial master with buffers, queue flushes, shared data line and start-up control.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module spim_control import spim_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic miso_i,
    input wire logic sdat_i,
    input wire logic ext_clk_i,
    output logic mosi_o,
    output logic sdat_o,
    output logic sdat_oe_o,
    output logic sclk_o,
    output logic ss_n_o,
    output logic event_o
);
    // One control command bit decoded from a register write.
    function automatic logic cmd(input logic wr, input logic [7:0] addr, input logic [31:0] wd, input int idx);
        return wr && (addr == ADDR_CTRL) && wd[idx];
    endfunction : cmd

    spim_stream_if #(.W(DATA_W)) txi ();
    spim_stream_if #(.W(DATA_W)) txo ();
    spim_stream_if #(.W(DATA_W)) rxi ();
    spim_stream_if #(.W(DATA_W)) rxo ();

    spim_state_type state;
    logic [31:0] cfg;
    logic [15:0] mask;
    logic [7:0] period;
    logic [7:0] div;
    logic enabled;
    logic irq_en;
    logic pending;
    logic line_drive;
    logic byte_done;
    logic spi_done;
    logic overrun;
    logic [DATA_W-1:0] sh;
    logic [2:0] bit_cnt;
    logic rx_bit;
    logic ext_prev;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic [RING_AW-1:0] tx_wptr;
    logic [RING_AW-1:0] tx_rptr;
    logic [RING_AW:0] tx_cnt;
    logic [RING_AW-1:0] rx_wptr;
    logic [RING_AW-1:0] rx_rptr;
    logic [RING_AW:0] rx_cnt;
    logic [DATA_W-1:0] tx_q;
    logic [DATA_W-1:0] rx_q;

    // Command decode.
    wire c_init = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_INIT);
    wire c_act = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_ACTIVATE);
    wire c_lp_in = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_LP_ENTRY);
    wire c_lp_out = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_LP_EXIT);
    wire c_on = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_DRIVE_ON);
    wire c_off = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_DRIVE_OFF);
    wire hw_flush = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_QUEUE_FLUSH) || c_init || c_lp_out;
    wire rx_flush = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_RX_FLUSH) || c_lp_out;
    wire tx_flush = cmd(reg_wr_i, reg_addr_i, reg_wdata_i, CTRL_TX_FLUSH) || c_lp_out;
    wire rxq_flush = hw_flush || rx_flush;
    wire wr_tx = reg_wr_i && (reg_addr_i == ADDR_TXDATA);
    wire rd_rx = reg_rd_i && (reg_addr_i == ADDR_RXDATA);
    wire rd_status = reg_rd_i && (reg_addr_i == ADDR_STATUS);
    wire stat_clr = hw_flush || rd_status;

    // Bit clock: internal divider, or the qualified external clock rising edge.
    wire int_clk = cfg[CFG_INT_CLK];
    wire tick = enabled && (int_clk ? (div == period) : (lvl[2] && !ext_prev));
    wire in_bit = cfg[CFG_BIDIR] ? lvl[1] : lvl[0];
    wire shifting = (state == SPIM_SHIFT);
    wire word_end = shifting && tick && sclk_o && (bit_cnt == LAST_BIT);
    wire take = txo.valid && !hw_flush && (((state == SPIM_IDLE) && enabled) || word_end);

    // Queue hookups; the receive queue takes the finished word for one cycle.
    assign txo.ready = take;
    assign rxi.valid = word_end;
    assign rxi.data = {sh[DATA_W-2:0], rx_bit};

    // Ring movement; a full transmit ring refuses further writes.
    wire tx_push = wr_tx && (tx_cnt != RING_DEPTH) && !tx_flush;
    wire tx_move = (tx_cnt != '0) && !tx_flush && !hw_flush;
    wire rx_move = rxo.valid && (rx_cnt != RING_DEPTH) && !rx_flush;
    wire rx_pop = rd_rx && (rx_cnt != '0) && !rx_flush;
    assign txi.valid = tx_move;
    assign txi.data = tx_q;
    assign rxo.ready = rx_move;
    wire tx_go = tx_move && txi.ready;
    wire [RING_AW-1:0] next_tx_rptr = tx_flush ? '0 : tx_rptr + RING_AW'(tx_go);
    wire [RING_AW-1:0] next_tx_wptr = tx_flush ? '0 : tx_wptr + RING_AW'(tx_push);
    wire [RING_AW-1:0] next_rx_rptr = rx_flush ? '0 : rx_rptr + RING_AW'(rx_pop);
    wire [RING_AW-1:0] next_rx_wptr = rx_flush ? '0 : rx_wptr + RING_AW'(rx_move);
    wire [RING_AW:0] next_tx_cnt = tx_flush ? '0 : tx_cnt + {{RING_AW{1'b0}}, tx_push} - {{RING_AW{1'b0}}, tx_go};
    wire [RING_AW:0] next_rx_cnt = rx_flush ? '0 : rx_cnt + {{RING_AW{1'b0}}, rx_move} - {{RING_AW{1'b0}}, rx_pop};

    // Status word: live queue flags plus sticky event bits.
    wire [15:0] status_word = {pending, overrun, rxo.valid, !rxi.ready, 4'h0, pending, 2'h0, state == SPIM_IDLE,
                               byte_done, txi.ready, !txo.valid, spi_done};
    wire [31:0] count_word = {20'h0, rx_cnt, 4'h0, tx_cnt};
    wire [31:0] rd_word = (reg_addr_i == ADDR_CFG) ? cfg :
                          (reg_addr_i == ADDR_MASK) ? {16'h0, mask} :
                          (reg_addr_i == ADDR_RXDATA) ? {24'h0, rx_q} :
                          (reg_addr_i == ADDR_STATUS) ? {16'h0, status_word} :
                          (reg_addr_i == ADDR_COUNT) ? count_word : 32'h0;

    spim_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_tx_fifo (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .flush_i(hw_flush), .in_s(txi), .out_s(txo));
    spim_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rx_fifo (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .flush_i(rxq_flush), .in_s(rxi), .out_s(rxo));
    spim_ring_mem #(.W(DATA_W), .AW(RING_AW)) u_tx_ring (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(tx_push), .wr_addr_i(tx_wptr),
        .wr_data_i(reg_wdata_i[DATA_W-1:0]), .rd_addr_i(next_tx_rptr), .rd_data_o(tx_q));
    spim_ring_mem #(.W(DATA_W), .AW(RING_AW)) u_rx_ring (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(rx_move), .wr_addr_i(rx_wptr),
        .wr_data_i(rxo.data), .rd_addr_i(next_rx_rptr), .rd_data_o(rx_q));

    // Pin synchronisers; a new level counts once the last two stages agree.
    wire [2:0] pin_raw = {ext_clk_i, sdat_i, miso_i};
    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    {s1[g], s2[g], s3[g], lvl[g]} <= 4'h0;
                else
                begin
                    s1[g] <= pin_raw[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    lvl[g] <= (s2[g] == s3[g]) ? s3[g] : lvl[g];
                end
            end
        end
    endgenerate

    // Configuration, mask, enables and the read register.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg <= CFG_RESET;
            mask <= MASK_INIT;
            period <= CFG_RESET[CFG_PERIOD_LSB+:8];
            enabled <= 1'b0;
            irq_en <= 1'b0;
            reg_rdata_o <= 32'h0;
        end
        else
        begin
            if (reg_wr_i && (reg_addr_i == ADDR_CFG))
                cfg <= reg_wdata_i;
            if (c_init)
                mask <= MASK_INIT;
            else if (reg_wr_i && (reg_addr_i == ADDR_MASK))
                mask <= reg_wdata_i[15:0];
            if (c_init)
                period <= cfg[CFG_PERIOD_LSB+:8];
            enabled <= (c_act || c_lp_out) ? 1'b1 : (c_lp_in ? 1'b0 : enabled);
            irq_en <= (c_act || c_lp_out) ? 1'b1 : (c_lp_in ? 1'b0 : irq_en);
            reg_rdata_o <= reg_rd_i ? rd_word : 32'h0;
        end
    end

    // Sticky events, where a setting event beats a clear, and the pending flag, where a clear beats a setting event.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            byte_done <= 1'b0;
            spi_done <= 1'b0;
            overrun <= 1'b0;
            pending <= 1'b0;
            event_o <= 1'b0;
        end
        else
        begin
            byte_done <= word_end || (byte_done && !stat_clr);
            spi_done <= (word_end && !txo.valid) || (spi_done && !stat_clr);
            overrun <= (word_end && !rxi.ready) || (overrun && !stat_clr);
            pending <= !(c_act || hw_flush || rd_status) && (pending || ((status_word & mask) != 16'h0));
            event_o <= pending && irq_en;
        end
    end

    // Ring pointers and counts.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_wptr <= '0;
            tx_rptr <= '0;
            tx_cnt <= '0;
            rx_wptr <= '0;
            rx_rptr <= '0;
            rx_cnt <= '0;
        end
        else
        begin
            tx_wptr <= next_tx_wptr;
            tx_rptr <= next_tx_rptr;
            tx_cnt <= next_tx_cnt;
            rx_wptr <= next_rx_wptr;
            rx_rptr <= next_rx_rptr;
            rx_cnt <= next_rx_cnt;
        end
    end

    // Shared line direction (the block starts out receiving), bit divider and external edge history.
    // The divider rests outside a word, so the first serial rise comes a full half-bit after select.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {line_drive, sdat_oe_o, div, ext_prev} <= 11'h0;
        else
        begin
            line_drive <= c_on ? 1'b1 : (c_off ? 1'b0 : line_drive);
            sdat_oe_o <= cfg[CFG_BIDIR] && line_drive;
            div <= (!enabled || !int_clk || !shifting || (div == period)) ? 8'h0 : div + 8'h1;
            ext_prev <= lvl[2];
        end
    end

    // Shift engine, clock mode 0: sample on the rising edge, shift on the falling one.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= SPIM_IDLE;
            sh <= '0;
            bit_cnt <= 3'h0;
            rx_bit <= 1'b0;
            sclk_o <= 1'b0;
            ss_n_o <= 1'b1;
        end
        else
        begin
            case (state)
                SPIM_IDLE:
                begin
                    if (take)
                    begin
                        sh <= txo.data;
                        bit_cnt <= 3'h0;
                        ss_n_o <= 1'b0;
                        state <= SPIM_SHIFT;
                    end
                end
                SPIM_SHIFT:
                begin
                    if (!enabled)
                    begin
                        sclk_o <= 1'b0;
                        ss_n_o <= 1'b1;
                        state <= SPIM_IDLE;
                    end
                    else if (tick && !sclk_o)
                    begin
                        sclk_o <= 1'b1;
                        rx_bit <= in_bit;
                    end
                    else if (tick)
                    begin
                        sclk_o <= 1'b0;
                        bit_cnt <= bit_cnt + 3'h1;
                        sh <= take ? txo.data : {sh[DATA_W-2:0], rx_bit};
                        if (word_end && !take)
                        begin
                            ss_n_o <= 1'b1;
                            state <= SPIM_IDLE;
                        end
                    end
                end
                default:
                    state <= SPIM_IDLE;
            endcase
        end
    end

    assign mosi_o = sh[DATA_W-1];
    assign sdat_o = sh[DATA_W-1];

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_FLUSH_EMPTIES: assert property (hw_flush |=> !txo.valid && !rxo.valid)
        else $error("queue flush left a word behind");
    AST_FLUSH_STATUS: assert property (hw_flush && !word_end |=> !byte_done && !spi_done && !overrun && !pending)
        else $error("queue flush left status set");
    AST_DRIVE_ON: assert property (c_on && cfg[CFG_BIDIR] ##1 !c_off && cfg[CFG_BIDIR] |=> sdat_oe_o)
        else $error("shared line not driven after drive-on");
    AST_DRIVE_OFF: assert property (c_off |-> ##2 !sdat_oe_o)
        else $error("shared line still driven after drive-off");
    AST_RX_CLEAR: assert property (rx_flush |=> rx_cnt == '0 && rx_rptr == '0 && rx_wptr == '0)
        else $error("receive clear left pointers set");
    AST_TX_CLEAR: assert property (tx_flush && !hw_flush && txo.valid && !take |=> tx_cnt == '0 && txo.valid)
        else $error("transmit clear lost queued words or kept ring data");
    AST_INIT: assert property (c_init |=> mask == MASK_INIT && period == $past(cfg[CFG_PERIOD_LSB+:8]))
        else $error("initialise did not load mask and period");
    AST_ACTIVATE: assert property (c_act |=> enabled && irq_en && !pending ##1 !event_o)
        else $error("activate did not enable cleanly");
    AST_WAKE: assert property (c_lp_out |=> tx_cnt == '0 && rx_cnt == '0 && !txo.valid && enabled)
        else $error("wake-up left data behind");
    AST_OVERRUN: assert property (word_end && !rxi.ready |=> overrun)
        else $error("overrun not flagged");
    AST_FLUSH_WINS: assert property (rxq_flush && (word_end || rxo.valid) |=> !rxo.valid)
        else $error("flush lost to push or pop");

    COV_WORD: cover property (word_end);
    COV_OVERRUN: cover property (word_end && !rxi.ready);
    COV_TX_FULL: cover property (tx_cnt == RING_DEPTH && !txi.ready);
endmodule : spim_control

// ===== tb/spim_slave_model.sv
// Serial slave model that answers every word with a fixed reply in clock mode 0.
`timescale 1ns/1ps
module spim_slave_model #(
    parameter logic [7:0] REPLY = 8'h3c
) (
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic [7:0] last_word_o,
    output int word_cnt_o
);
    logic [7:0] shift_q = 8'h00;
    int nbits = 0;
    initial word_cnt_o = 0;
    initial miso_o = 1'b0;
    initial last_word_o = 8'h00;
    // Selection puts the first reply bit on the line before the first clock.
    always @(negedge ss_n_i)
    begin
        nbits = 0;
        miso_o = REPLY[7];
    end
    // Sample on the rising serial clock, msb first, and count whole words.
    always @(posedge sclk_i)
    begin
        if (!ss_n_i)
        begin
            shift_q = {shift_q[6:0], mosi_i};
            nbits = (nbits + 1) % 8;
            if (nbits == 0)
            begin
                word_cnt_o = word_cnt_o + 1;
                last_word_o = shift_q;
            end
        end
    end
    // Next reply bit goes out on the falling clock; a new word restarts at the msb.
    always @(negedge sclk_i)
    begin
        if (!ss_n_i)
            miso_o = REPLY[7 - nbits];
    end
    // A released line shows the inverse of its last value, so stale data never passes.
    always @(posedge ss_n_i)
    begin
        miso_o = ~miso_o;
    end
endmodule : spim_slave_model

// ===== tb/spim_control_bench.sv
// Self-checking bench of the serial master control block.
`timescale 1ns/1ps
module spim_control_bench import spim_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic miso, sdat_i, mosi_o, sdat_o, sdat_oe_o, sclk_o, ss_n_o, event_o;
    logic [7:0] last_word;
    logic [31:0] got;
    int words;
    int num_errors = 0;
    int n_compared = 0;
    // Register rows: write flag, address, write data, expected read-back.
    logic t_wr [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [7:0] t_addr [7] = '{ADDR_CFG, ADDR_MASK, ADDR_TXDATA, ADDR_MASK, ADDR_CTRL, 8'h1c, ADDR_CFG};
    logic [31:0] t_data [7] = '{32'h0, 32'h0, 32'h0, 32'h4000, 32'h0, 32'hffff_ffff, 32'h0403};
    logic [31:0] t_exp [7] = '{CFG_RESET, 32'h0001, 32'h0, 32'h4000, 32'h0, 32'h0, 32'h0403};
    // The shared line carries the block's value while it drives, the slave's otherwise.
    assign sdat_i = sdat_oe_o ? sdat_o : miso;
    always #12.5 clk_i = ~clk_i;
    // Free-running external bit clock of eight system cycles, used once the block selects it.
    logic [2:0] ext_div = 3'h0;
    always @(posedge clk_i)
        ext_div <= ext_div + 3'h1;
    spim_control dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .miso_i(miso), .sdat_i(sdat_i),
        .ext_clk_i(ext_div[2]), .mosi_o(mosi_o), .sdat_o(sdat_o), .sdat_oe_o(sdat_oe_o), .sclk_o(sclk_o),
        .ss_n_o(ss_n_o), .event_o(event_o));
    spim_slave_model slave (.sclk_i(sclk_o), .ss_n_i(ss_n_o), .mosi_i(mosi_o), .miso_o(miso),
        .last_word_o(last_word), .word_cnt_o(words));
    // Comparison, bus cycles and waits shared by all scenarios.
    task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        got = reg_rdata_o;
        check(what, exp, got);
    endtask : rdc
    task ctl(input int bitn);
        wr(ADDR_CTRL, 32'h1 << bitn);
    endtask : ctl
    task settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle
    task wait_words(input int n);
        for (int i = 0; i < 4000 && words < n; i++)
            @(posedge clk_i);
        repeat (200) @(posedge clk_i);
    endtask : wait_words
    task give_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // Main sequence: reset, register rows, then the hand-written cases.
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("idle pins", 32'h8, {28'h0, ss_n_o, sdat_oe_o, sclk_o, event_o});
        for (int i = 0; i < 7; i++)
        begin
            if (t_wr[i])
                wr(t_addr[i], t_data[i]);
            rdc("register row", t_addr[i], t_exp[i]);
        end
        ctl(CTRL_DRIVE_ON);
        settle();
        check("drive on", 32'h1, sdat_oe_o);
        ctl(CTRL_DRIVE_OFF);
        settle();
        check("drive off", 32'h0, sdat_oe_o);
        wr(ADDR_CFG, 32'h0401);
        ctl(CTRL_DRIVE_ON);
        settle();
        check("drive on four wire", 32'h0, sdat_oe_o);
        ctl(CTRL_DRIVE_OFF);
        ctl(CTRL_INIT);
        rdc("mask after init", ADDR_MASK, 32'h0001);
        ctl(CTRL_ACTIVATE);
        settle();
        check("event after activate", 32'h0, event_o);
        wr(ADDR_TXDATA, 32'ha5);
        wait_words(1);
        check("slave word", 32'ha5, last_word);
        rdc("rx count", ADDR_COUNT, 32'h0100);
        rdc("rx data", ADDR_RXDATA, 32'h3c);
        // Twelve words fill ring and queue on the far side; one more overruns.
        wr(ADDR_MASK, 32'h4000);
        rdc("status before burst", ADDR_STATUS, 32'h809f);
        for (int i = 0; i < 12; i++)
            wr(ADDR_TXDATA, i);
        wait_words(13);
        wr(ADDR_TXDATA, 32'hff);
        wait_words(14);
        check("overrun event", 32'h1, event_o);
        rdc("rx ring full", ADDR_COUNT, 32'h0800);
        ctl(CTRL_QUEUE_FLUSH);
        rdc("status after flush", ADDR_STATUS, 32'h16);
        check("queue status", 32'h0, got[14:12]);
        check("event after flush", 32'h0, event_o);
        ctl(CTRL_RX_FLUSH);
        rdc("rx flushed", ADDR_COUNT, 32'h0);
        // Engine stopped: four words sit in the queue, two in the ring.
        ctl(CTRL_LP_ENTRY);
        for (int i = 0; i < 6; i++)
            wr(ADDR_TXDATA, 32'h10 + i);
        rdc("tx ring", ADDR_COUNT, 32'h0002);
        ctl(CTRL_TX_FLUSH);
        rdc("tx flushed", ADDR_COUNT, 32'h0);
        ctl(CTRL_ACTIVATE);
        wait_words(18);
        check("queued words sent", 18, words);
        rdc("four received", ADDR_COUNT, 32'h0400);
        ctl(CTRL_LP_ENTRY);
        for (int i = 0; i < 13; i++)
            wr(ADDR_TXDATA, i);
        rdc("tx ring refused", ADDR_COUNT, 32'h0408);
        ctl(CTRL_LP_EXIT);
        rdc("after wake", ADDR_COUNT, 32'h0);
        repeat (300) @(posedge clk_i);
        check("no stale words", 18, words);
        // Shared line: the reply comes back over the data pin, then the block hears its own word.
        wr(ADDR_CFG, 32'h0403);
        wr(ADDR_TXDATA, 32'h5a);
        wait_words(19);
        check("shared line word", 32'h5a, last_word);
        rdc("shared line reply", ADDR_RXDATA, 32'h3c);
        ctl(CTRL_DRIVE_ON);
        wr(ADDR_TXDATA, 32'h69);
        wait_words(20);
        rdc("shared line echo", ADDR_RXDATA, 32'h69);
        // External bit clock, already running, paces one word.
        wr(ADDR_CFG, 32'h0400);
        wr(ADDR_TXDATA, 32'hc3);
        wait_words(21);
        check("external clock word", 32'hc3, last_word);
        give_verdict();
    end
    // Watchdog reckoned well beyond the twenty-one words the sequence sends.
    initial
    begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
endmodule : spim_control_bench
